// [src/mtac_defines.svh]
// register offsets, field positions and reset values of the abort counters
`ifndef MTAC_DEFINES_SVH
`define MTAC_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define MTAC_UND_IDX 10'h334
`define MTAC_ALL_IDX 10'h338
`define MTAC_CTRL_IDX 10'h000
`define MTAC_IDX_LSB 2
`define MTAC_IDX_MSB 11
`define MTAC_HI_MSB 31
`define MTAC_HI_LSB 12

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define MTAC_CTRL_LATCH_BIT 0
`define MTAC_CTRL_RST 1'h0
`define MTAC_CNT_RST 32'h00000000
`define MTAC_CNT_ONE 32'h00000001
`define MTAC_MSB_LANE 2'h0

`endif

// [src/mtac_pkg.sv]
// types shared by the abort counter block
package mtac_pkg;

   // ----------------------------------------------------------------
   // data types
   // ----------------------------------------------------------------
   typedef logic [31:0] mtac_word_t;
   typedef logic [7:0] mtac_byte_t;

   // register group selected by a bus address
   typedef enum logic [1:0] {
      MTAC_SEL_NONE,
      MTAC_SEL_CTRL,
      MTAC_SEL_UND,
      MTAC_SEL_ALL
   } mtac_sel_t;

endpackage

// [src/mtac_abort_ctr.sv]
// one wrapping 32-bit event counter with a read snapshot
`timescale 1ns/10ps
`default_nettype none
`include "mtac_defines.svh"

module mtac_abort_ctr
   import mtac_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic inc,
   input wire logic cap,
   output logic [31:0] count,
   output logic [31:0] snap
);

   // ----------------------------------------------------------------
   // counter
   // ----------------------------------------------------------------
   mtac_word_t count_ff;
   mtac_word_t nxt_count;
   mtac_word_t snap_ff;

   // plain add, the carry out of bit 31 is dropped so all-ones wraps
   assign nxt_count = count_ff + `MTAC_CNT_ONE;

   // only reset clears the count; inc is the only other path that touches it
   always_ff @(posedge clk) begin
      if (rst) begin
         count_ff <= `MTAC_CNT_RST;
      end else if (inc) begin
         count_ff <= nxt_count;
      end
   end

   // snapshot keeps a multi-byte read coherent
   always_ff @(posedge clk) begin
      if (rst) begin
         snap_ff <= `MTAC_CNT_RST;
      end else if (cap) begin
         snap_ff <= count_ff;
      end
   end

   assign count = count_ff;
   assign snap = snap_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_ctr_wrap: assert property (@(posedge clk) disable iff (rst)
      (inc && (count_ff == 32'hFFFFFFFF)) |=> (count_ff == `MTAC_CNT_RST))
      else $error("counter did not wrap to zero");

   cov_ctr_wrap: cover property (@(posedge clk) disable iff (rst)
      inc && (count_ff == 32'hFFFFFFFF));

endmodule
`default_nettype wire

// [src/mtac_top.sv]
// transmit abort statistics counters behind an ahb-lite slave
`timescale 1ns/10ps
`default_nettype none
`include "mtac_defines.svh"

module mtac_top
   import mtac_pkg::*;
(
   input wire logic CLOCK,
   input wire logic RESET,
   input wire logic UNDERRUN_ABORT,
   input wire logic ANY_ABORT,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic HREADYOUT,
   output logic HRESP,
   output logic [31:0] HRDATA
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic und_inc;
   logic all_inc;
   logic acc;
   logic rd_acc;
   logic wr_acc;
   logic [9:0] idx;
   logic [1:0] lane;
   mtac_sel_t sel;
   logic cap_und;
   logic cap_all;
   logic latch_ff;
   logic wr_ctrl_ff;
   mtac_word_t und_cnt;
   mtac_word_t und_snap;
   mtac_word_t all_cnt;
   mtac_word_t all_snap;
   mtac_word_t src;
   mtac_word_t nxt_rdata;
   mtac_word_t rdata_ff;

   // ----------------------------------------------------------------
   // event inputs
   // ----------------------------------------------------------------

   // strobes come from the mac transmit path on this clock
   assign und_inc = UNDERRUN_ABORT;
   // an underrun abort is an abort too, so it feeds the total
   assign all_inc = ANY_ABORT | UNDERRUN_ABORT;

   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------

   // underrun-caused aborts
   mtac_abort_ctr u_und_ctr (
      .clk(CLOCK),
      .rst(RESET),
      .inc(und_inc),
      .cap(cap_und),
      .count(und_cnt),
      .snap(und_snap)
   );

   // aborts for any reason
   mtac_abort_ctr u_all_ctr (
      .clk(CLOCK),
      .rst(RESET),
      .inc(all_inc),
      .cap(cap_all),
      .count(all_cnt),
      .snap(all_snap)
   );

   // ----------------------------------------------------------------
   // address phase decode
   // ----------------------------------------------------------------

   // a transfer is taken when selected, nonseq/seq and bus ready
   assign acc = HSEL && HREADY && HTRANS[1];
   assign rd_acc = acc && !HWRITE;
   assign wr_acc = acc && HWRITE;
   assign idx = HADDR[`MTAC_IDX_MSB:`MTAC_IDX_LSB];
   assign lane = idx[1:0];

   // pick the register group; upper address bits must be zero
   always_comb begin
      sel = MTAC_SEL_NONE;
      if (HADDR[`MTAC_HI_MSB:`MTAC_HI_LSB] == 20'h00000) begin
         if (idx == `MTAC_CTRL_IDX) begin
            sel = MTAC_SEL_CTRL;
         end else if ((idx & 10'h3FC) == `MTAC_UND_IDX) begin
            sel = MTAC_SEL_UND;
         end else if ((idx & 10'h3FC) == `MTAC_ALL_IDX) begin
            sel = MTAC_SEL_ALL;
         end
      end
   end

   // a read of the top byte in latch mode freezes the whole count
   assign cap_und = rd_acc && latch_ff && (sel == MTAC_SEL_UND)
      && (lane == `MTAC_MSB_LANE);
   assign cap_all = rd_acc && latch_ff && (sel == MTAC_SEL_ALL)
      && (lane == `MTAC_MSB_LANE);

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------

   // top byte reads live; lower bytes read the snapshot in latch mode
   always_comb begin
      src = `MTAC_CNT_RST;
      case (sel)
         MTAC_SEL_UND: begin
            src = (latch_ff && (lane != `MTAC_MSB_LANE)) ? und_snap : und_cnt;
         end
         MTAC_SEL_ALL: begin
            src = (latch_ff && (lane != `MTAC_MSB_LANE)) ? all_snap : all_cnt;
         end
         default: begin
            src = `MTAC_CNT_RST;
         end
      endcase
   end

   // lowest location gives bits 31:24, highest gives bits 7:0
   always_comb begin
      nxt_rdata = `MTAC_CNT_RST;
      case (sel)
         MTAC_SEL_CTRL: begin
            nxt_rdata = {31'h0, latch_ff};
         end
         MTAC_SEL_UND, MTAC_SEL_ALL: begin
            case (lane)
               2'h0: nxt_rdata = {24'h000000, src[31:24]};
               2'h1: nxt_rdata = {24'h000000, src[23:16]};
               2'h2: nxt_rdata = {24'h000000, src[15:8]};
               default: nxt_rdata = {24'h000000, src[7:0]};
            endcase
         end
         default: begin
            nxt_rdata = `MTAC_CNT_RST;
         end
      endcase
   end

   // read data is loaded at the address phase edge
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         rdata_ff <= `MTAC_CNT_RST;
      end else if (rd_acc) begin
         rdata_ff <= nxt_rdata;
      end
   end

   // ----------------------------------------------------------------
   // write path
   // ----------------------------------------------------------------

   // only the control word is writable; counter bytes ignore writes
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         wr_ctrl_ff <= 1'h0;
      end else if (HREADY) begin
         wr_ctrl_ff <= wr_acc && (sel == MTAC_SEL_CTRL);
      end
   end

   // latch mode bit takes the data phase write
   always_ff @(posedge CLOCK) begin
      if (RESET) begin
         latch_ff <= `MTAC_CTRL_RST;
      end else if (wr_ctrl_ff) begin
         latch_ff <= HWDATA[`MTAC_CTRL_LATCH_BIT];
      end
   end

   // ----------------------------------------------------------------
   // bus outputs
   // ----------------------------------------------------------------

   // zero wait states, always okay
   assign HREADYOUT = 1'h1;
   assign HRESP = 1'h0;
   assign HRDATA = rdata_ff;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge CLOCK); endclocking
   default disable iff (RESET);

   chk_und_count: assert property (
      UNDERRUN_ABORT |=> (und_cnt == $past(und_cnt) + `MTAC_CNT_ONE))
      else $error("underrun count did not step by one");

   chk_all_count: assert property (
      ANY_ABORT |=> (all_cnt == $past(all_cnt) + `MTAC_CNT_ONE))
      else $error("abort count did not step by one");

   chk_und_both: assert property (
      UNDERRUN_ABORT |=> ((all_cnt - $past(all_cnt)) == `MTAC_CNT_ONE)
         && ((und_cnt - $past(und_cnt)) == `MTAC_CNT_ONE))
      else $error("underrun abort did not step both counters");

   chk_all_stable: assert property (
      !(ANY_ABORT || UNDERRUN_ABORT) |=> $stable(all_cnt))
      else $error("abort count moved without an abort");

   chk_und_stable: assert property (
      !UNDERRUN_ABORT |=> $stable(und_cnt))
      else $error("underrun count moved without an underrun");

   chk_reset_zero: assert property (
      $fell(RESET) |-> (und_cnt == `MTAC_CNT_RST) && (all_cnt == `MTAC_CNT_RST)
         && (HRDATA == `MTAC_CNT_RST))
      else $error("counters not zero after reset");

   chk_all_msb: assert property (
      (rd_acc && (sel == MTAC_SEL_ALL) && (lane == 2'h0))
         |=> (HRDATA == {24'h000000, $past(all_cnt[31:24])}))
      else $error("all-aborts top byte read wrong");

   chk_und_lsb: assert property (
      (rd_acc && !latch_ff && (sel == MTAC_SEL_UND) && (lane == 2'h3))
         |=> (HRDATA == {24'h000000, $past(und_cnt[7:0])}))
      else $error("underrun low byte read wrong");

   // both strobes together still add one to the total
   chk_all_once: assert property (
      (UNDERRUN_ABORT && ANY_ABORT) |=> ((all_cnt - $past(all_cnt)) == `MTAC_CNT_ONE))
      else $error("double strobe counted twice");

   // a write to any location leaves both counts alone
   chk_write_keeps: assert property (
      (wr_acc && !ANY_ABORT && !UNDERRUN_ABORT) ##1 (!ANY_ABORT && !UNDERRUN_ABORT)
         |=> ($stable(und_cnt) && $stable(all_cnt)))
      else $error("write moved a counter");

   // ----------------------------------------------------------------
   // read path checks
   // ----------------------------------------------------------------

   // live byte order of the underrun count, top byte first
   chk_und_msb: assert property (
      (rd_acc && (sel == MTAC_SEL_UND) && (lane == 2'h0))
         |=> (HRDATA == {24'h000000, $past(und_cnt[31:24])}))
      else $error("underrun top byte read wrong");

   chk_und_byte1: assert property (
      (rd_acc && !latch_ff && (sel == MTAC_SEL_UND) && (lane == 2'h1))
         |=> (HRDATA == {24'h000000, $past(und_cnt[23:16])}))
      else $error("underrun byte one read wrong");

   chk_und_byte2: assert property (
      (rd_acc && !latch_ff && (sel == MTAC_SEL_UND) && (lane == 2'h2))
         |=> (HRDATA == {24'h000000, $past(und_cnt[15:8])}))
      else $error("underrun byte two read wrong");

   // live byte order of the all-aborts count
   chk_all_byte1: assert property (
      (rd_acc && !latch_ff && (sel == MTAC_SEL_ALL) && (lane == 2'h1))
         |=> (HRDATA == {24'h000000, $past(all_cnt[23:16])}))
      else $error("all-aborts byte one read wrong");

   chk_all_byte2: assert property (
      (rd_acc && !latch_ff && (sel == MTAC_SEL_ALL) && (lane == 2'h2))
         |=> (HRDATA == {24'h000000, $past(all_cnt[15:8])}))
      else $error("all-aborts byte two read wrong");

   chk_all_lsb: assert property (
      (rd_acc && !latch_ff && (sel == MTAC_SEL_ALL) && (lane == 2'h3))
         |=> (HRDATA == {24'h000000, $past(all_cnt[7:0])}))
      else $error("all-aborts low byte read wrong");

   // counter locations carry one byte, upper bits read zero
   chk_byte_upper: assert property (
      (rd_acc && ((sel == MTAC_SEL_UND) || (sel == MTAC_SEL_ALL)))
         |=> (HRDATA[31:8] == 24'h000000))
      else $error("counter read upper bits not zero");

   // read data stands until the next read is taken
   chk_rdata_hold: assert property (
      !rd_acc |=> $stable(HRDATA))
      else $error("read data moved without a read");

   // latch mode: the top byte read freezes the whole count
   chk_snap_take: assert property (
      cap_und |=> (und_snap == $past(und_cnt)))
      else $error("snapshot missed the live count");

   chk_snap_read: assert property (
      (rd_acc && latch_ff && (sel == MTAC_SEL_UND) && (lane == 2'h3))
         |=> (HRDATA == {24'h000000, $past(und_snap[7:0])}))
      else $error("latched low byte read wrong");

   // ----------------------------------------------------------------
   // coverage
   // ----------------------------------------------------------------
   cov_und_abort: cover property (UNDERRUN_ABORT ##1 ANY_ABORT);
   cov_rd_all: cover property (rd_acc && (sel == MTAC_SEL_ALL) ##1 rd_acc);
   cov_latch_rd: cover property (cap_und ##[1:8] (rd_acc && (sel == MTAC_SEL_UND)));
   cov_ctrl_write: cover property (wr_ctrl_ff ##1 latch_ff);

endmodule
`default_nettype wire

// [test/mtac_top_test.sv]
// self-checking bench for the transmit abort statistics counters
`timescale 1ns/10ps
`default_nettype none
`include "mtac_defines.svh"

module mtac_top_test
   import mtac_pkg::*;
;
   // ----------------------------------------------------------------
   // signals and bench state
   // ----------------------------------------------------------------
   localparam mtac_word_t UND_BASE = 32'(`MTAC_UND_IDX) << 2;
   localparam mtac_word_t ALL_BASE = 32'(`MTAC_ALL_IDX) << 2;
   localparam mtac_word_t CTRL_ADDR = 32'(`MTAC_CTRL_IDX) << 2;
   logic CLOCK, RESET, UNDERRUN_ABORT, ANY_ABORT, HSEL, HWRITE, HREADYOUT, HRESP;
   logic [1:0] HTRANS;
   logic [2:0] HSIZE;
   mtac_word_t HADDR, HWDATA, HRDATA, und_m, all_m, rd, snap, first_val, last_val;
   int err_total, total_checks, cycles;

   // ready loops back from the single slave
   mtac_top mtac_top_inst (
      .CLOCK(CLOCK),
      .RESET(RESET),
      .UNDERRUN_ABORT(UNDERRUN_ABORT),
      .ANY_ABORT(ANY_ABORT),
      .HSEL(HSEL),
      .HADDR(HADDR),
      .HTRANS(HTRANS),
      .HWRITE(HWRITE),
      .HSIZE(HSIZE),
      .HWDATA(HWDATA),
      .HREADY(HREADYOUT),
      .HREADYOUT(HREADYOUT),
      .HRESP(HRESP),
      .HRDATA(HRDATA)
   );

   // ----------------------------------------------------------------
   // clock, timeout and verdict
   // ----------------------------------------------------------------
   initial begin
      CLOCK = 1'b0;
      forever #2 CLOCK = ~CLOCK;
   end

   task automatic close_out();
      if (err_total == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // cut a hang short well past the expected run length
   always @(posedge CLOCK) begin
      cycles <= cycles + 1;
      if (cycles == 6000) begin
         err_total = err_total + 1;
         $display("CHECK FAILED at %0t: timeout", $time);
         close_out();
      end
   end

   // ----------------------------------------------------------------
   // bus and strobe tasks
   // ----------------------------------------------------------------
   task automatic chk(input mtac_word_t got, input mtac_word_t exp, input string what);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         err_total = err_total + 1;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   // one single word transfer; read data lands in rd
   task automatic xfer(input logic wr, input mtac_word_t addr, input mtac_word_t wdata);
      @(posedge CLOCK);
      HSEL <= 1'b1;
      HTRANS <= 2'h2;
      HWRITE <= wr;
      HADDR <= addr;
      HSIZE <= 3'h2;
      @(posedge CLOCK);
      while (HREADYOUT !== 1'b1) @(posedge CLOCK);
      HSEL <= 1'b0;
      HTRANS <= 2'h0;
      HWDATA <= wdata;
      @(posedge CLOCK);
      while (HREADYOUT !== 1'b1) @(posedge CLOCK);
      rd = HRDATA;
      chk({31'h0, HRESP}, 32'h0, "response");
   endtask

   // read bytes first..3 of a counter, most significant byte at +0
   task automatic chk_cnt(input mtac_word_t base, input mtac_word_t val, input int first);
      for (int i = first; i < 4; i++) begin
         xfer(1'b0, base + 32'(4 * i), 32'h0);
         chk(rd, {24'h0, 8'(val >> (24 - 8 * i))}, "counter byte");
      end
   endtask

   // gather a counter's four bytes into one word, msb first
   task automatic get_cnt(input mtac_word_t base, output mtac_word_t val);
      val = 32'h0;
      for (int i = 0; i < 4; i++) begin
         xfer(1'b0, base + 32'(4 * i), 32'h0);
         val = {val[23:0], rd[7:0]};
      end
   endtask

   // hold the strobes for n edges and advance the reference counts
   task automatic pulse(input logic u, input logic a, input int n);
      @(posedge CLOCK);
      UNDERRUN_ABORT <= u;
      ANY_ABORT <= a;
      repeat (n) @(posedge CLOCK);
      UNDERRUN_ABORT <= 1'b0;
      ANY_ABORT <= 1'b0;
      und_m = und_m + 32'(u ? n : 0);
      all_m = all_m + 32'((u | a) ? n : 0);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      RESET = 1'b1;
      {UNDERRUN_ABORT, ANY_ABORT, HSEL, HWRITE} = 4'h0;
      HTRANS = 2'h0;
      HSIZE = 3'h2;
      HADDR = 32'h0;
      HWDATA = 32'h0;
      {und_m, all_m, snap, rd, first_val, last_val} = {6{32'h0}};
      {err_total, total_checks, cycles} = {3{32'sh0}};
      repeat (20) @(posedge CLOCK);
      RESET <= 1'b0;
      chk_cnt(UND_BASE, und_m, 0);
      chk_cnt(ALL_BASE, all_m, 0);
      // unmapped places read zero
      xfer(1'b0, 32'h00000100, 32'h0);
      chk(rd, 32'h0, "unmapped read");
      xfer(1'b0, 32'h00001CEC, 32'h0);
      chk(rd, 32'h0, "high address read");
      // each strobe mix, including both at once
      pulse(1'b1, 1'b0, 1);
      chk_cnt(UND_BASE, und_m, 0);
      chk_cnt(ALL_BASE, all_m, 0);
      pulse(1'b0, 1'b1, 2);
      chk_cnt(UND_BASE, und_m, 0);
      chk_cnt(ALL_BASE, all_m, 0);
      pulse(1'b1, 1'b1, 3);
      pulse(1'b1, 1'b0, 300);
      chk_cnt(UND_BASE, und_m, 0);
      chk_cnt(ALL_BASE, all_m, 0);
      // rereads and writes leave the counts alone
      xfer(1'b1, UND_BASE, 32'hFFFFFFFF);
      xfer(1'b1, ALL_BASE + 32'hC, 32'h000000FF);
      chk_cnt(UND_BASE, und_m, 0);
      chk_cnt(ALL_BASE, all_m, 0);
      // latch mode: top byte read freezes the lower bytes
      xfer(1'b1, CTRL_ADDR, 32'h00000001);
      xfer(1'b0, CTRL_ADDR, 32'h0);
      chk(rd & 32'h1, 32'h1, "latch mode bit");
      xfer(1'b0, UND_BASE, 32'h0);
      snap = und_m;
      pulse(1'b1, 1'b0, 260);
      chk_cnt(UND_BASE, snap, 1);
      chk_cnt(UND_BASE, und_m, 0);
      // measure an interval from a stored start; the difference wraps
      get_cnt(ALL_BASE, first_val);
      pulse(1'b0, 1'b1, 5);
      get_cnt(ALL_BASE, last_val);
      chk(last_val - first_val, 32'h00000005, "interval difference");
      chk(last_val, all_m, "latched total");
      xfer(1'b1, CTRL_ADDR, 32'h0);
      // mid-run reset clears both counts
      @(posedge CLOCK);
      RESET <= 1'b1;
      repeat (2) @(posedge CLOCK);
      RESET <= 1'b0;
      und_m = 32'h0;
      all_m = 32'h0;
      chk_cnt(UND_BASE, und_m, 0);
      chk_cnt(ALL_BASE, all_m, 0);
      close_out();
   end

endmodule
`default_nettype wire
